// ===== sfsre_cfg.svh
// Constants for the serial flash status, read and sector wipe block
`ifndef SFSRE_CFG_SVH
`define SFSRE_CFG_SVH
`define SFSRE_OP_ARM 8'h06
`define SFSRE_OP_DISARM 8'h04
`define SFSRE_OP_STR 8'h05
`define SFSRE_OP_STW 8'h01
`define SFSRE_OP_READ 8'h03
`define SFSRE_OP_FAST 8'h0B
`define SFSRE_OP_DUAL 8'h3B
`define SFSRE_OP_WIPE 8'h20
`define SFSRE_N_CMD 7'h08
`define SFSRE_N_STW 7'h10
`define SFSRE_N_ADDR 7'h20
`define SFSRE_N_FAST 7'h28
`define SFSRE_N_DUAL_ADDR 7'h14
`define SFSRE_N_DUAL 7'h18
`define SFSRE_N_SAT 7'h7F
`define SFSRE_SGL_PH_LAST 3'h7
`define SFSRE_DUAL_PH_LAST 3'h3
`define SFSRE_SECT_LSB 12
`define SFSRE_ADDR_W 16
`define SFSRE_BLANK_BYTE 8'hFF
`define SFSRE_CLK_NS 20
`define SFSRE_STW_TIME_NS 5000000
`define SFSRE_WIPE_TIME_NS 45000000
`define SFSRE_LOCK_RST 1'h0
`define SFSRE_PROT_RST 4'h0
`endif

// ===== sfsre_pkg.sv
// Types shared by the serial flash status, read and sector wipe block
package sfsre_pkg;
  typedef enum logic [1:0] {
    SFSRE_IDLE = 2'h0,
    SFSRE_TIMED = 2'h1,
    SFSRE_DONE = 2'h3
  } sfsre_state_t;
  typedef enum logic [2:0] {
    SFSRE_C_NONE = 3'h0,
    SFSRE_C_ARM = 3'h1,
    SFSRE_C_DISARM = 3'h2,
    SFSRE_C_STW = 3'h3,
    SFSRE_C_WIPE = 3'h4
  } sfsre_cmt_t;
  typedef struct packed {
    logic status_lock_bit;
    logic zero;
    logic [3:0] protect_level_bits;
    logic write_latch_flag;
    logic busy_flag;
  } sfsre_status_t;
  typedef struct packed {
    logic tog;
    sfsre_cmt_t code;
    logic [7:0] stw_byte;
    logic [23:0] addr;
  } sfsre_commit_t;
endpackage

// ===== sfsre_core.sv
// Serial flash command logic: status byte, reads and 4K sector wipe
`timescale 1ns/100ps
`include "sfsre_cfg.svh"
module sfsre_core #(
  parameter int ADDR_W = `SFSRE_ADDR_W,
  parameter int STW_CYC = `SFSRE_STW_TIME_NS / `SFSRE_CLK_NS,
  parameter int WIPE_CYC = `SFSRE_WIPE_TIME_NS / `SFSRE_CLK_NS
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic i_io0,
  output logic o_io0,
  output logic o_io0_oe,
  input wire logic i_io1,
  output logic o_io1,
  output logic o_io1_oe
);
  localparam int SECT_W = ADDR_W - `SFSRE_SECT_LSB;
  localparam int NSECT = 1 << SECT_W;

  // Protect level n shields the top 2^(n-1) sectors; level zero shields nothing
  function automatic logic prot_hit(input logic [3:0] lvl, input logic [SECT_W-1:0] sect);
    int span;
    span = (lvl == 4'h0) ? 0 : (1 << (int'(lvl) - 1));
    return (int'(sect) >= NSECT - span);
  endfunction

  // Unwiped bytes show their low address byte, wiped sectors read all ones
  function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] a,
                                          input logic [NSECT-1:0] bl);
    return bl[a[ADDR_W-1:`SFSRE_SECT_LSB]] ? `SFSRE_BLANK_BYTE : a[7:0];
  endfunction

  // ---------------- Link side, clocked by the serial clock ----------------
  logic frame_rst_n;
  logic [6:0] n_ff;
  logic [7:0] cmd_ff;
  logic [23:0] addr_ff;
  logic [7:0] stw_ff;
  logic rej_ff;
  sfsre_pkg::sfsre_commit_t commit_ff;
  sfsre_pkg::sfsre_commit_t nxt_commit;
  sfsre_pkg::sfsre_cmt_t nxt_code;
  sfsre_pkg::sfsre_status_t status_byte;
  logic [2:0][7:0] st_sync_ff;
  logic [NSECT-1:0] blank_ff;
  logic [2:0][NSECT-1:0] bl_sync_ff;
  logic [7:0] st_q_ff;
  logic [NSECT-1:0] bl_q_ff;

  // Chip select high ends the frame at once, even with the clock stopped
  assign frame_rst_n = i_resetn & ~i_cs_n;

  // Bit decode: one count of rising edges drives every phase boundary
  wire [6:0] nxt_n = (n_ff == `SFSRE_N_SAT) ? n_ff : n_ff + 7'h01;
  wire in_cmd = n_ff < `SFSRE_N_CMD;
  wire [7:0] nxt_cmd = in_cmd ? {cmd_ff[6:0], i_io0} : cmd_ff;
  wire is_dual = cmd_ff == `SFSRE_OP_DUAL;
  wire is_sgl_addr = (cmd_ff == `SFSRE_OP_READ) | (cmd_ff == `SFSRE_OP_FAST) |
                     (cmd_ff == `SFSRE_OP_WIPE);
  wire addr_sgl = ~in_cmd & (n_ff < `SFSRE_N_ADDR) & is_sgl_addr;
  wire addr_dual = ~in_cmd & is_dual & (n_ff < `SFSRE_N_DUAL_ADDR);
  wire [23:0] nxt_addr = addr_dual ? {addr_ff[21:0], i_io1, i_io0} :
                         addr_sgl ? {addr_ff[22:0], i_io0} : addr_ff;
  wire stw_in = ~in_cmd & (n_ff < `SFSRE_N_STW) & (cmd_ff == `SFSRE_OP_STW);
  wire [7:0] nxt_stw = stw_in ? {stw_ff[6:0], i_io0} : stw_ff;
  wire busy_l = st_q_ff[0];

  // Commit code only survives if chip select rises on this very edge count
  assign nxt_code = (nxt_cmd == `SFSRE_OP_ARM && nxt_n == `SFSRE_N_CMD) ?
                      sfsre_pkg::SFSRE_C_ARM :
                    (nxt_cmd == `SFSRE_OP_DISARM && nxt_n == `SFSRE_N_CMD) ?
                      sfsre_pkg::SFSRE_C_DISARM :
                    (nxt_cmd == `SFSRE_OP_STW && nxt_n == `SFSRE_N_STW) ?
                      sfsre_pkg::SFSRE_C_STW :
                    (nxt_cmd == `SFSRE_OP_WIPE && nxt_n == `SFSRE_N_ADDR) ?
                      sfsre_pkg::SFSRE_C_WIPE :
                    sfsre_pkg::SFSRE_C_NONE;
  // Toggle flips on the first edge so a frame without clocks commits nothing
  assign nxt_commit = '{tog: (n_ff == 7'h00) ? ~commit_ff.tog : commit_ff.tog,
                        code: nxt_code,
                        stw_byte: nxt_stw,
                        addr: nxt_addr};

  // Input shift on rising edges within the frame
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      n_ff <= '0;
      cmd_ff <= '0;
      addr_ff <= '0;
      stw_ff <= '0;
      rej_ff <= 1'h0;
    end else begin
      n_ff <= nxt_n;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      stw_ff <= nxt_stw;
      if (nxt_n == `SFSRE_N_CMD) begin
        rej_ff <= busy_l;
      end
    end
  end

  // Commit word must outlive the frame, so chip select does not clear it
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      commit_ff <= '0;
    end else begin
      commit_ff <= nxt_commit;
    end
  end

  // Status and wipe map into the link domain; they can change at any time, even mid-frame
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_sync_ff <= '0;
      bl_sync_ff <= '0;
    end else begin
      st_sync_ff <= {st_sync_ff[1:0], status_byte};
      bl_sync_ff <= {bl_sync_ff[1:0], blank_ff};
    end
  end

  // Copies move only once two stages agree, so a word caught mid-change never shows
  always_ff @(posedge i_sclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q_ff <= '0;
      bl_q_ff <= '0;
    end else begin
      if (st_sync_ff[1] == st_sync_ff[2]) begin
        st_q_ff <= st_sync_ff[2];
      end
      if (bl_sync_ff[1] == bl_sync_ff[2]) begin
        bl_q_ff <= bl_sync_ff[2];
      end
    end
  end

  // Output phase decode
  logic [2:0] ph_ff;
  logic first_ff;
  logic [ADDR_W-1:0] rd_ff;
  logic [7:0] sh_ff;
  logic o1_ff;
  logic o0_ff;
  logic oe1_ff;
  logic oe0_ff;
  wire is_read = (cmd_ff == `SFSRE_OP_READ) | (cmd_ff == `SFSRE_OP_FAST) | is_dual;
  wire [6:0] hdr = (cmd_ff == `SFSRE_OP_READ) ? `SFSRE_N_ADDR :
                   (cmd_ff == `SFSRE_OP_FAST) ? `SFSRE_N_FAST :
                   is_dual ? `SFSRE_N_DUAL :
                   (cmd_ff == `SFSRE_OP_STR) ? `SFSRE_N_CMD : `SFSRE_N_SAT;
  wire out_act = (n_ff >= hdr) & (hdr != `SFSRE_N_SAT) &
                 ~(is_read & rej_ff);
  wire [2:0] ph_last = is_dual ? `SFSRE_DUAL_PH_LAST : `SFSRE_SGL_PH_LAST;
  wire [ADDR_W-1:0] byte_addr = first_ff ? addr_ff[ADDR_W-1:0] : rd_ff;
  wire [7:0] load_byte = (cmd_ff == `SFSRE_OP_STR) ? st_q_ff :
                         mem_byte(byte_addr, bl_q_ff);
  wire [7:0] cur = (ph_ff == 3'h0) ? load_byte : sh_ff;

  // Data leaves on falling edges, msb first; the address wraps by its width
  always_ff @(negedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      ph_ff <= '0;
      first_ff <= 1'h1;
      rd_ff <= '0;
      sh_ff <= '0;
      o1_ff <= 1'h0;
      o0_ff <= 1'h0;
      oe1_ff <= 1'h0;
      oe0_ff <= 1'h0;
    end else if (out_act) begin
      o1_ff <= cur[7];
      o0_ff <= cur[6];
      sh_ff <= is_dual ? {cur[5:0], 2'h0} : {cur[6:0], 1'h0};
      oe1_ff <= 1'h1;
      oe0_ff <= is_dual;
      ph_ff <= (ph_ff == ph_last) ? 3'h0 : ph_ff + 3'h1;
      if (ph_ff == 3'h0) begin
        first_ff <= 1'h0;
        rd_ff <= ADDR_W'(byte_addr + 1'h1);
      end
    end
  end

  assign o_io1 = o1_ff;
  assign o_io0 = o0_ff;
  assign o_io1_oe = oe1_ff;
  assign o_io0_oe = oe0_ff;

  // Only the dual read may ever drive the second line
  dual_lines_a: assert property (@(negedge i_sclk) disable iff (!frame_rst_n)
    o_io0_oe |-> is_dual)
    else $error("second data line driven outside dual read");
  // A read that was refused at decode never drives the output line
  read_refused_a: assert property (@(negedge i_sclk) disable iff (!frame_rst_n)
    (is_read && rej_ff) |=> !o_io1_oe)
    else $error("read driven while a timed cycle runs");

  // ---------------- System side, clocked by i_clk_sys ----------------
  logic [2:0] cs_sync_ff;
  logic [2:0] wp_sync_ff;
  logic cs_q_ff;
  logic wp_q_ff;
  sfsre_pkg::sfsre_commit_t [2:0] cm_sync_ff;
  logic last_tog_ff;
  sfsre_pkg::sfsre_state_t state_ff;
  sfsre_pkg::sfsre_state_t nxt_state;
  logic [31:0] timer_ff;
  logic kind_stw_ff;
  logic [7:0] pend_byte_ff;
  logic [SECT_W-1:0] pend_sect_ff;
  logic wel_ff;
  logic lock_ff;
  logic [3:0] prot_ff;

  // Pins and the commit word pass three stages; levels count once two agree
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      cs_sync_ff <= '1;
      wp_sync_ff <= '1;
      cs_q_ff <= 1'h1;
      wp_q_ff <= 1'h1;
      cm_sync_ff <= '0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], i_cs_n};
      wp_sync_ff <= {wp_sync_ff[1:0], i_wp_n};
      cm_sync_ff <= {cm_sync_ff[1:0], commit_ff};
      if (cs_sync_ff[1] == cs_sync_ff[2]) begin
        cs_q_ff <= cs_sync_ff[2];
      end
      if (wp_sync_ff[1] == wp_sync_ff[2]) begin
        wp_q_ff <= wp_sync_ff[2];
      end
    end
  end

  // Command acceptance at the chip select rise
  sfsre_pkg::sfsre_commit_t cm_q;
  assign cm_q = cm_sync_ff[2];
  wire cs_rise = cs_sync_ff[1] & cs_sync_ff[2] & ~cs_q_ff;
  wire exec = cs_rise & (cm_q.tog != last_tog_ff);
  wire idle = state_ff == sfsre_pkg::SFSRE_IDLE;
  wire hw_lock = lock_ff & ~wp_q_ff;
  wire [SECT_W-1:0] cm_sect = cm_q.addr[ADDR_W-1:`SFSRE_SECT_LSB];
  wire cm_prot = prot_hit(prot_ff, cm_sect);
  wire do_arm = exec & idle & (cm_q.code == sfsre_pkg::SFSRE_C_ARM);
  wire do_disarm = exec & idle & (cm_q.code == sfsre_pkg::SFSRE_C_DISARM);
  wire go_stw = exec & idle & wel_ff & ~hw_lock &
                (cm_q.code == sfsre_pkg::SFSRE_C_STW);
  wire go_wipe = exec & idle & wel_ff & ~cm_prot &
                 (cm_q.code == sfsre_pkg::SFSRE_C_WIPE);
  wire start = go_stw | go_wipe;
  wire finish = state_ff == sfsre_pkg::SFSRE_DONE;
  wire [31:0] load_cyc = go_stw ? 32'(STW_CYC - 1) : 32'(WIPE_CYC - 1);

  // Self-timed cycle sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sfsre_pkg::SFSRE_IDLE: begin
        if (start) begin
          nxt_state = sfsre_pkg::SFSRE_TIMED;
        end
      end
      sfsre_pkg::SFSRE_TIMED: begin
        if (timer_ff == 32'h0) begin
          nxt_state = sfsre_pkg::SFSRE_DONE;
        end
      end
      sfsre_pkg::SFSRE_DONE: begin
        nxt_state = sfsre_pkg::SFSRE_IDLE;
      end
      default: begin
        nxt_state = sfsre_pkg::SFSRE_IDLE;
      end
    endcase
  end

  // Cycle timer and the pending command
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= sfsre_pkg::SFSRE_IDLE;
      timer_ff <= '0;
      kind_stw_ff <= 1'h0;
      pend_byte_ff <= '0;
      pend_sect_ff <= '0;
      last_tog_ff <= 1'h0;
    end else begin
      state_ff <= nxt_state;
      if (exec) begin
        last_tog_ff <= cm_q.tog;
      end
      if (start) begin
        timer_ff <= load_cyc;
        kind_stw_ff <= go_stw;
        pend_byte_ff <= cm_q.stw_byte;
        pend_sect_ff <= cm_sect;
      end else if (state_ff == sfsre_pkg::SFSRE_TIMED && timer_ff != 32'h0) begin
        timer_ff <= timer_ff - 32'h1;
      end
    end
  end

  // Status bits; arming is only taken while idle, so it never meets a clear
  sfsre_pkg::sfsre_status_t pend_st;
  assign pend_st = sfsre_pkg::sfsre_status_t'(pend_byte_ff);
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      wel_ff <= 1'h0;
      lock_ff <= `SFSRE_LOCK_RST;
      prot_ff <= `SFSRE_PROT_RST;
      blank_ff <= '0;
    end else begin
      if (do_arm) begin
        wel_ff <= 1'h1;
      end else if (do_disarm || finish) begin
        wel_ff <= 1'h0;
      end
      if (finish && kind_stw_ff) begin
        lock_ff <= pend_st.status_lock_bit;
        prot_ff <= pend_st.protect_level_bits;
      end
      if (finish && !kind_stw_ff) begin
        blank_ff[pend_sect_ff] <= 1'h1;
      end
    end
  end

  // Read-back layout; bit6 is hard zero
  assign status_byte = '{status_lock_bit: lock_ff,
                         zero: 1'h0,
                         protect_level_bits: prot_ff,
                         write_latch_flag: wel_ff,
                         busy_flag: ~idle};

  sequence cycle_end_s;
    finish ##1 (idle && !wel_ff && !status_byte.busy_flag);
  endsequence
  sequence busy_two_s;
    status_byte.busy_flag [*2];
  endsequence

  arm_sets_latch_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    do_arm |=> status_byte.write_latch_flag)
    else $error("write arm did not set the latch");
  latch_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (exec && idle && !wel_ff && (cm_q.code == sfsre_pkg::SFSRE_C_STW ||
     cm_q.code == sfsre_pkg::SFSRE_C_WIPE)) |=> idle)
    else $error("changing command ran without the write latch");
  lock_rejects_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (exec && idle && lock_ff && !wp_q_ff && cm_q.code == sfsre_pkg::SFSRE_C_STW)
    |=> (idle && $stable(wel_ff)))
    else $error("status write ran in hardware lock mode");
  lock_frozen_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (hw_lock && idle) |=> ($stable(lock_ff) && $stable(prot_ff)))
    else $error("lock or level changed in hardware lock mode");
  prot_ignore_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (exec && idle && wel_ff && cm_prot && cm_q.code == sfsre_pkg::SFSRE_C_WIPE)
    |=> (idle && wel_ff))
    else $error("protected wipe was not ignored");
  busy_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    start |=> busy_two_s)
    else $error("busy flag did not follow cycle start");
  cycle_end_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (state_ff == sfsre_pkg::SFSRE_TIMED && timer_ff == 32'h0) |=> cycle_end_s)
    else $error("timed cycle did not end with busy and latch clear");
  wipe_blank_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
    (finish && !kind_stw_ff) |=> blank_ff[$past(pend_sect_ff)])
    else $error("wiped sector not marked blank");
endmodule // sfsre_core

// ===== sfsre_host_mdl.sv
// Behavioural SPI host that frames commands for the flash block
`timescale 1ns/100ps
module sfsre_host_mdl (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_io0,
  output logic o_io1,
  input wire logic i_io0,
  input wire logic i_io1
);
  logic r0;
  logic r1;
  // Mode 0 idle: clock low, chip select high
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_io0 = 1'b0;
    o_io1 = 1'b1;
  end
  // Lines change while the clock is low; device samples and host reads at the rise
  task automatic pulse(input logic b1, input logic b0);
    o_io1 = b1;
    o_io0 = b0;
    #3 o_sclk = 1'b1;
    r1 = i_io1;
    r0 = i_io0;
    #3 o_sclk = 1'b0;
  endtask
  // One frame; the clock stands still outside it
  task automatic frame(input int ns, input logic [39:0] tx, input int nd,
                       input logic [31:0] txd, input int nr, input logic dual,
                       output logic [31:0] rx);
    rx = 32'h0;
    o_cs_n = 1'b0;
    #5;
    for (int i = ns - 1; i >= 0; i--) pulse(~tx[i], tx[i]);
    for (int i = nd - 1; i >= 0; i--) pulse(txd[2*i+1], txd[2*i]);
    for (int i = 0; i < nr; i++) begin
      pulse(~o_io1, ~o_io0); // Released lines toggle so a stale level never passes
      rx = dual ? {rx[29:0], r1, r0} : {rx[30:0], r1};
    end
    #3 o_cs_n = 1'b1; // Rise right after the last bit sent
    #10;
  endtask
endmodule // sfsre_host_mdl

// ===== sfsre_core_tb.sv
// Self-checking bench for the serial flash status, read and sector wipe block
`timescale 1ns/100ps
`include "sfsre_cfg.svh"
`define TB_CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end
module sfsre_core_tb;
  logic i_clk_sys;
  logic i_resetn;
  logic i_wp_n;
  logic sclk;
  logic cs_n;
  logic h_io0;
  logic h_io1;
  logic o_io0;
  logic o_io0_oe;
  logic o_io1;
  logic o_io1_oe;
  logic seen0;
  logic seen1;
  logic [31:0] rx;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  // Wire level: whoever enables drives, otherwise the host's value
  wire logic io0_w = o_io0_oe ? o_io0 : h_io0;
  wire logic io1_w = o_io1_oe ? o_io1 : h_io1;
  // Short timed cycles keep the run brief
  sfsre_core #(.ADDR_W(16), .STW_CYC(20), .WIPE_CYC(100)) dut (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_wp_n(i_wp_n), .i_io0(io0_w), .o_io0(o_io0), .o_io0_oe(o_io0_oe),
    .i_io1(io1_w), .o_io1(o_io1), .o_io1_oe(o_io1_oe));
  sfsre_host_mdl host (.o_sclk(sclk), .o_cs_n(cs_n), .o_io0(h_io0), .o_io1(h_io1),
    .i_io0(io0_w), .i_io1(io1_w));
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // Sticky record of which lines the device drove during a frame
  always @(posedge sclk) begin
    if (o_io0_oe === 1'b1) seen0 = 1'b1;
    if (o_io1_oe === 1'b1) seen1 = 1'b1;
  end
  // Hang guard, well above the fewer than 1500 cycles the sequence needs
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wsys(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask
  // Sys-side effect lands a few cycles after chip select rises, so wait it out
  task automatic cmd(input int n, input logic [39:0] v);
    host.frame(n, v, 0, 32'h0, 0, 1'b0, rx);
    wsys(10);
  endtask
  task automatic arm();
    cmd(8, {32'h0, `SFSRE_OP_ARM});
  endtask
  task automatic stw(input logic [7:0] v);
    cmd(16, {24'h0, `SFSRE_OP_STW, v});
  endtask
  task automatic set_wp(input logic v);
    @(posedge i_clk_sys) i_wp_n <= v;
    wsys(8);
  endtask
  // Status read of two bytes: the byte must repeat
  task automatic chk_st(input string nm, input logic [7:0] e);
    host.frame(8, {32'h0, `SFSRE_OP_STR}, 0, 32'h0, 16, 1'b0, rx);
    `TB_CHK(nm, {e, e}, rx[15:0])
    wsys(4);
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
    seen0 = 1'b0;
    seen1 = 1'b0;
    if (op == `SFSRE_OP_DUAL) host.frame(8, {32'h0, op}, 16, {a, 8'h00}, 4 * n, 1'b1, rx);
    else if (op == `SFSRE_OP_FAST) host.frame(40, {op, a, 8'h00}, 0, 32'h0, 8 * n, 1'b0, rx);
    else host.frame(32, {8'h00, op, a}, 0, 32'h0, 8 * n, 1'b0, rx);
    wsys(4);
  endtask
  task automatic s_latch();
    chk_st("reset status", 8'h00);
    cmd(9, {31'h0, `SFSRE_OP_ARM, 1'b0});
    chk_st("arm nine bits", 8'h00);
    arm();
    chk_st("armed", 8'h02);
    cmd(8, {32'h0, `SFSRE_OP_DISARM});
    chk_st("disarmed", 8'h00);
  endtask
  task automatic s_stw();
    stw(8'hFF);
    chk_st("stw unarmed", 8'h00);
    arm();
    cmd(17, {23'h0, `SFSRE_OP_STW, 8'hFF, 1'b0});
    chk_st("stw 17 bits", 8'h02);
    stw(8'hFF);
    chk_st("stw busy", 8'h03);
    wsys(40);
    chk_st("stw done", 8'hBC);
  endtask
  task automatic s_lock();
    set_wp(1'b0);
    arm();
    stw(8'h00);
    chk_st("locked refuse", 8'hBE);
    set_wp(1'b1);
    stw(8'h00);
    wsys(40);
    chk_st("pin high unlock", 8'h00);
    set_wp(1'b0);
    arm();
    stw(8'h80);
    wsys(40);
    chk_st("lock under low pin", 8'h80);
    arm();
    stw(8'h00);
    chk_st("pin first lock", 8'h82);
    set_wp(1'b1);
    stw(8'h00);
    wsys(40);
    chk_st("unlocked again", 8'h00);
  endtask
  task automatic s_reads();
    rd(`SFSRE_OP_READ, 24'h00FFFF, 3);
    `TB_CHK("read wrap", 24'hFF0001, rx[23:0])
    `TB_CHK("single io0 idle", 1'b0, seen0)
    rd(`SFSRE_OP_FAST, 24'h001234, 2);
    `TB_CHK("fast read", 16'h3435, rx[15:0])
    rd(`SFSRE_OP_DUAL, 24'h0000FE, 3);
    `TB_CHK("dual read", 24'hFEFF00, rx[23:0])
    `TB_CHK("dual io0 drive", 1'b1, seen0)
  endtask
  task automatic s_wipe();
    cmd(32, {8'h00, `SFSRE_OP_WIPE, 24'h002345});
    chk_st("wipe unarmed", 8'h00);
    arm();
    cmd(31, {9'h0, `SFSRE_OP_WIPE, 23'h002345});
    chk_st("wipe 31 bits", 8'h02);
    cmd(32, {8'h00, `SFSRE_OP_WIPE, 24'h002345});
    chk_st("wipe busy", 8'h03);
    rd(`SFSRE_OP_FAST, 24'h000010, 1);
    `TB_CHK("fast while busy", 1'b0, seen1)
    rd(`SFSRE_OP_READ, 24'h000010, 1);
    `TB_CHK("read while busy", 1'b0, seen1)
    rd(`SFSRE_OP_DUAL, 24'h000010, 1);
    `TB_CHK("dual while busy", 2'b00, {seen1, seen0})
    wsys(150);
    chk_st("wipe done", 8'h00);
    rd(`SFSRE_OP_READ, 24'h001FFE, 3);
    `TB_CHK("sector low edge", {16'hFEFF, `SFSRE_BLANK_BYTE}, rx[23:0])
    rd(`SFSRE_OP_READ, 24'h002FFF, 2);
    `TB_CHK("sector high edge", 16'hFF00, rx[15:0])
  endtask
  task automatic s_protect();
    arm();
    stw(8'h04);
    wsys(40);
    chk_st("level one", 8'h04);
    arm();
    cmd(32, {8'h00, `SFSRE_OP_WIPE, 24'h00F000});
    chk_st("protected wipe", 8'h06);
    rd(`SFSRE_OP_READ, 24'h00F001, 1);
    `TB_CHK("protected kept", 8'h01, rx[7:0])
    cmd(32, {8'h00, `SFSRE_OP_WIPE, 24'h00E000});
    wsys(150);
    chk_st("open wipe done", 8'h04);
    rd(`SFSRE_OP_READ, 24'h00E000, 1);
    `TB_CHK("open sector wiped", 8'hFF, rx[7:0])
  endtask
  // Reset held three cycles, then every scenario in turn
  initial begin
    i_resetn = 1'b0;
    i_wp_n = 1'b1;
    seen0 = 1'b0;
    seen1 = 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    wsys(5);
    s_latch();
    s_stw();
    s_lock();
    s_reads();
    s_wipe();
    s_protect();
    complete_run();
  end
endmodule // sfsre_core_tb
